// [rtl/sw_array_dev.sv]
// switch array end: 32-stage shift register, output latches, clear
`timescale 1ns/1ns
module sw_array_dev
	import sw_array_pkg::*;
#(
	parameter int WIDTH = CHANNELS
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// serial link
	sw_link_if.array_end link,
	// switch drive, bit 0 = first terminal, top bit = last terminal
	output logic [WIDTH-1:0] switch_on_o,
	output logic [WIDTH-1:0] shift_state_o
);
	// two-flop synchronisers, one pair per link input pin
	logic [1:0] sclk_sync_r;
	logic [1:0] sclk_sync_nxt;
	logic [1:0] din_sync_r;
	logic [1:0] din_sync_nxt;
	logic [1:0] load_sync_r;
	logic [1:0] load_sync_nxt;
	logic [1:0] clr_sync_r;
	logic [1:0] clr_sync_nxt;
	// edge detectors behind the second stage
	logic sclk_prev_r;
	logic sclk_prev_nxt;
	logic load_prev_r;
	logic load_prev_nxt;
	// strobes decoded from the synchronised pins
	logic sclk_rise;
	logic load_fall;
	logic load_open;
	logic clr_level;
	logic din_bit;
	// shift register and the serial output behind it
	logic [WIDTH-1:0] shift_r;
	logic [WIDTH-1:0] shift_nxt;
	logic dout_r;
	logic dout_nxt;
	// output latches, one per switch, and the switch drive
	logic [WIDTH-1:0] latch_r;
	wire logic [WIDTH-1:0] latch_nxt;
	logic [WIDTH-1:0] switch_nxt;

	// pins come from another device: two flops before any logic reads them
	always_comb
	begin
		sclk_sync_nxt = {sclk_sync_r[0], link.sclk};
		din_sync_nxt = {din_sync_r[0], link.sdata_in};
		load_sync_nxt = {load_sync_r[0], link.latch_load_n};
		clr_sync_nxt = {clr_sync_r[0], link.latch_clear};
	end

	// reset to idle pin levels, so no false edge follows reset
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			sclk_sync_r <= 2'h0;
			din_sync_r <= 2'h0;
			load_sync_r <= 2'h3;
			clr_sync_r <= 2'h0;
		end
		else
		begin
			sclk_sync_r <= sclk_sync_nxt;
			din_sync_r <= din_sync_nxt;
			load_sync_r <= load_sync_nxt;
			clr_sync_r <= clr_sync_nxt;
		end
	end

	// edge detectors read only the second synchroniser stage
	always_comb
	begin
		sclk_prev_nxt = sclk_sync_r[1];
		load_prev_nxt = load_sync_r[1];
	end

	// idle levels: serial clock low, latch load high
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			sclk_prev_r <= 1'b0;
			load_prev_r <= 1'b1;
		end
		else
		begin
			sclk_prev_r <= sclk_prev_nxt;
			load_prev_r <= load_prev_nxt;
		end
	end

	// strobes: each edge is one system clock wide
	always_comb
	begin
		sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
		load_fall = ~load_sync_r[1] & load_prev_r;
		load_open = load_fall | ~load_sync_r[1];
		clr_level = clr_sync_r[1];
		din_bit = din_sync_r[1];
	end

	// rising serial clock moves every stage up by one; clear has no say here
	always_comb
	begin
		shift_nxt = shift_r;
		if (sclk_rise)
			shift_nxt = {shift_r[WIDTH-2:0], din_bit};
	end

	// register view leaves on the same edge as the register
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			shift_r <= SHIFT_RESET[WIDTH-1:0];
			shift_state_o <= SHIFT_RESET[WIDTH-1:0];
		end
		else
		begin
			shift_r <= shift_nxt;
			shift_state_o <= shift_nxt;
		end
	end

	// serial output tracks the last stage, moving with the register
	always_comb
	begin
		dout_nxt = shift_nxt[WIDTH-1];
	end

	// registered so the next device in a chain sees a clean level
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			dout_r <= SHIFT_RESET[WIDTH-1];
		end
		else
		begin
			dout_r <= dout_nxt;
		end
	end

	// one latch per switch: clear wins, an open load follows the register, else hold
	for (genvar ch = 0; ch < WIDTH; ch++)
	begin : g_latch
		assign latch_nxt[ch] = clr_level ? 1'b0 :
			load_open ? shift_nxt[ch] :
			latch_r[ch];
	end

	// latch state
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			latch_r <= LATCH_RESET[WIDTH-1:0];
		end
		else
		begin
			latch_r <= latch_nxt;
		end
	end

	// each switch bit copies its own latch, 1 = on
	always_comb
	begin
		switch_nxt = latch_nxt;
	end

	// switch drive leaves a flip-flop, no logic between latch and port
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			switch_on_o <= LATCH_RESET[WIDTH-1:0];
		end
		else
		begin
			switch_on_o <= switch_nxt;
		end
	end

	// serial output pin for the next device or a read-back
	assign link.sdata_out = dout_r;
endmodule

// [rtl/sw_array_pkg.sv]
// shared constants for the switch array serial link
package sw_array_pkg;
	localparam int CHANNELS = 32;
	localparam int LAST_STAGE = 31;
	localparam logic [31:0] SHIFT_RESET = 32'h0000_0000;
	localparam logic [31:0] LATCH_RESET = 32'h0000_0000;
	// serial clock rate limit and derived half period in system clocks
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int SCLK_MAX_HZ = 66_000_000;
	localparam int SCLK_HALF_CYC = (SYS_CLK_HZ / (2 * SCLK_MAX_HZ)) < 1 ? 1 : (SYS_CLK_HZ / (2 * SCLK_MAX_HZ));
	localparam logic [7:0] HALF_CNT_RESET = 8'h00;
	localparam logic [15:0] BIT_CNT_RESET = 16'h0000;
endpackage

// [rtl/sw_link_if.sv]
// serial link between controller and switch array chain
`timescale 1ns/1ns
interface sw_link_if;
	logic sclk;
	logic sdata_in;
	logic sdata_out;
	logic latch_load_n;
	logic latch_clear;
	modport array_end (input sclk, input sdata_in, input latch_load_n, input latch_clear, output sdata_out);
	modport ctrl_end (output sclk, output sdata_in, output latch_load_n, output latch_clear, input sdata_out);
endinterface

// [rtl/sw_array_ctrl.sv]
// controller end: shifts a chain of words out and pulses latch load
`timescale 1ns/1ns
module sw_array_ctrl
	import sw_array_pkg::*;
#(
	parameter int DEVICES = 1,
	parameter int HALF_CYC = SCLK_HALF_CYC
)
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// user request
	input wire logic start_i,
	input wire logic [DEVICES*CHANNELS-1:0] config_i,
	input wire logic clear_i,
	output logic busy_o,
	output logic done_o,
	output logic [DEVICES*CHANNELS-1:0] readback_o,
	// serial link
	sw_link_if.ctrl_end link
);
	localparam int NBITS = DEVICES * CHANNELS;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOW = 4'b0010,
		ST_HIGH = 4'b0100,
		ST_LOAD = 4'b1000
	} ctrl_state_t;
	ctrl_state_t state_r;
	ctrl_state_t state_nxt;
	logic [NBITS-1:0] data_r;
	logic [NBITS-1:0] data_nxt;
	logic [NBITS-1:0] rb_r;
	logic [NBITS-1:0] rb_nxt;
	logic [15:0] bits_r;
	logic [15:0] bits_nxt;
	logic [7:0] half_r;
	logic [7:0] half_nxt;
	logic [1:0] dout_sync_r;
	logic sclk_nxt;
	logic sdata_nxt;
	logic load_n_nxt;
	logic clr_nxt;
	logic done_nxt;
	logic half_tick;

	assign half_tick = (half_r == 8'(HALF_CYC - 1));

	// sequence: shift all bits msb first, then one latch load low pulse
	always_comb
	begin
		state_nxt = state_r;
		data_nxt = data_r;
		rb_nxt = rb_r;
		bits_nxt = bits_r;
		half_nxt = half_tick ? HALF_CNT_RESET : half_r + 8'h01;
		sclk_nxt = link.sclk;
		sdata_nxt = link.sdata_in;
		load_n_nxt = 1'b1;
		clr_nxt = clear_i;
		done_nxt = 1'b0;
		unique case (state_r)
			ST_IDLE:
			begin
				half_nxt = HALF_CNT_RESET;
				sclk_nxt = 1'b0;
				if (start_i)
				begin
					state_nxt = ST_LOW;
					data_nxt = config_i;
					bits_nxt = BIT_CNT_RESET;
					clr_nxt = 1'b0;
				end
			end
			ST_LOW:
			begin
				clr_nxt = 1'b0;
				sdata_nxt = data_r[NBITS-1];
				if (half_tick)
				begin
					state_nxt = ST_HIGH;
					sclk_nxt = 1'b1;
					rb_nxt = {rb_r[NBITS-2:0], dout_sync_r[1]};
				end
			end
			ST_HIGH:
			begin
				clr_nxt = 1'b0;
				if (half_tick)
				begin
					sclk_nxt = 1'b0;
					data_nxt = {data_r[NBITS-2:0], 1'b0};
					bits_nxt = bits_r + 16'h0001;
					state_nxt = (bits_r == 16'(NBITS - 1)) ? ST_LOAD : ST_LOW;
				end
			end
			ST_LOAD:
			begin
				clr_nxt = 1'b0;
				load_n_nxt = 1'b0;
				if (half_tick)
				begin
					state_nxt = ST_IDLE;
					done_nxt = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= ST_IDLE;
			data_r <= '0;
			rb_r <= '0;
			bits_r <= BIT_CNT_RESET;
			half_r <= HALF_CNT_RESET;
			dout_sync_r <= 2'h0;
			link.sclk <= 1'b0;
			link.sdata_in <= 1'b0;
			link.latch_load_n <= 1'b1;
			link.latch_clear <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			readback_o <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			data_r <= data_nxt;
			rb_r <= rb_nxt;
			bits_r <= bits_nxt;
			half_r <= half_nxt;
			dout_sync_r <= {dout_sync_r[0], link.sdata_out};
			link.sclk <= sclk_nxt;
			link.sdata_in <= sdata_nxt;
			link.latch_load_n <= load_n_nxt;
			link.latch_clear <= clr_nxt;
			busy_o <= (state_nxt != ST_IDLE);
			done_o <= done_nxt;
			readback_o <= done_nxt ? rb_r : readback_o;
		end
	end
endmodule

// [sim/sw_link_sva.sv]
// assertions on the serial link between controller and switch array
`timescale 1ns/1ns
module sw_link_sva (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic sclk,
	input wire logic sdata_in,
	input wire logic sdata_out,
	input wire logic latch_load_n,
	input wire logic latch_clear
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// wire framing, half period of four system clocks
	sclk_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("sclk high phase wrong");
	load_high_shift_a: assert property ($rose(sclk) |-> latch_load_n)
		else $error("latch load low while shifting");
	clear_low_shift_a: assert property ($rose(sclk) |-> !latch_clear)
		else $error("clear high while shifting");
	data_stable_a: assert property ($changed(sdata_in) |-> !sclk)
		else $error("data changed while sclk high");
	load_pulse_a: assert property ($fell(latch_load_n) |-> !latch_load_n [*4] ##1 latch_load_n)
		else $error("latch load pulse length wrong");
	no_clk_load_a: assert property (!latch_load_n |-> !sclk)
		else $error("sclk high during load");
	dout_hold_a: assert property ($fell(sclk) |-> ##1 $stable(sdata_out) [*4])
		else $error("serial output moved between shifts");
	clear_keep_a: assert property ($rose(latch_clear) |-> $stable(sdata_out) [*3])
		else $error("clear disturbed shift register");
	// main scenarios
	cover property ($fell(latch_load_n));
	cover property ($rose(latch_clear));
	cover property ($rose(sclk) && sdata_in);
endmodule

// [sim/switch_array_serial_latch_bench.sv]
// self-checking bench for the controller and switch array pair
`timescale 1ns/1ns
module switch_array_serial_latch_bench;
	import sw_array_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic start_i = 1'b0;
	logic clear_i = 1'b0;
	logic [31:0] config_i = 32'h0000_0000;
	logic busy_o;
	logic done_o;
	logic [31:0] readback_o;
	logic [31:0] switch_on_o;
	logic [31:0] shift_state_o;
	logic [31:0] prev = 32'h0000_0000;
	logic [31:0] cur = 32'h0000_0000;
	int n_mismatch = 0;
	int comparisons = 0;
	sw_link_if link ();
	// 20 MHz clock
	always #25 sys_clk_i = ~sys_clk_i;
	sw_array_ctrl #(.DEVICES(1), .HALF_CYC(4)) sw_array_ctrl_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.start_i(start_i), .config_i(config_i), .clear_i(clear_i), .busy_o(busy_o), .done_o(done_o),
		.readback_o(readback_o), .link(link));
	sw_array_dev sw_array_dev_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link),
		.switch_on_o(switch_on_o), .shift_state_o(shift_state_o));
	sw_link_sva sw_link_sva_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sclk(link.sclk),
		.sdata_in(link.sdata_in), .sdata_out(link.sdata_out), .latch_load_n(link.latch_load_n),
		.latch_clear(link.latch_clear));
	// compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// expected register after pushing a word in, switch 31 bit first
	function automatic logic [31:0] pushed(input logic [31:0] old, input logic [31:0] v);
		logic [31:0] r;
		int b;
		r = old;
		for (b = 31; b >= 0; b--)
			r = {r[30:0], v[b]};
		return r;
	endfunction
	// expected read-back: the bit leaving stage 31 before each push
	function automatic logic [31:0] pulled(input logic [31:0] old, input logic [31:0] v);
		logic [31:0] r;
		logic [31:0] q;
		int b;
		r = old;
		q = 32'h0000_0000;
		for (b = 31; b >= 0; b--)
		begin
			q = {q[30:0], r[31]};
			r = {r[30:0], v[b]};
		end
		return q;
	endfunction
	// full shift-then-latch transfer with a refused start midway
	task automatic send(input logic [31:0] v);
		int i;
		config_i = v;
		start_i = 1'b1;
		wait_cyc(1);
		start_i = 1'b0;
		config_i = ~v;
		wait_cyc(100);
		check("hold", switch_on_o, cur);
		check("busy", {31'h0000_0000, busy_o}, 32'h0000_0001);
		start_i = 1'b1;
		wait_cyc(1);
		start_i = 1'b0;
		for (i = 0; i < 2000 && done_o !== 1'b1; i++)
			wait_cyc(1);
		if (i == 2000)
		begin
			n_mismatch++;
			close_out();
		end
		wait_cyc(8);
		check("switches", switch_on_o, pushed(prev, v));
		check("shift", shift_state_o, pushed(prev, v));
		check("readback", readback_o, pulled(prev, v));
		check("serial out", {31'h0000_0000, link.sdata_out}, {31'h0000_0000, pushed(prev, v)[31]});
		check("idle", {31'h0000_0000, busy_o}, 32'h0000_0000);
		prev = pushed(prev, v);
		cur = prev;
	endtask
	// main sequence
	initial
	begin
		int k;
		void'($urandom(5));
		wait_cyc(16);
		sys_rst_i = 1'b0;
		wait_cyc(2);
		send(32'hFFFF_FFFF);
		send(32'h8000_0001);
		clear_i = 1'b1;
		wait_cyc(8);
		check("cleared", switch_on_o, 32'h0000_0000);
		check("kept", shift_state_o, 32'h8000_0001);
		clear_i = 1'b0;
		cur = 32'h0000_0000;
		wait_cyc(8);
		check("stay", switch_on_o, cur);
		send(32'h5555_AAAA);
		for (k = 0; k < 4; k++)
			send($urandom);
		close_out();
	end
endmodule
